// File: pkg/serial_flash_defines.svh
`ifndef SERIAL_FLASH_DEFINES_SVH
`define SERIAL_FLASH_DEFINES_SVH
`define OP_BLOCK_ERASE 8'h50
`define OP_PTB_BUF1 8'h82
`define OP_PTB_BUF2 8'h85
`define OP_XFER_BUF1 8'h53
`define OP_XFER_BUF2 8'h55
`define OP_CMP_BUF1 8'h60
`define OP_CMP_BUF2 8'h61
`define OP_REWR_BUF1 8'h58
`define OP_REWR_BUF2 8'h59
`define CMD_BITS 32
`define CMD_CNT_W 6
`define OPC_MSB 31
`define OPC_LSB 24
`define PAGE_MSB 19
`define PAGE_LSB 9
`define BLOCK_MSB 19
`define BLOCK_LSB 12
`define BYTE_MSB 8
`define BYTE_LSB 0
`define PAGE_BYTES 264
`define PAGES_PER_BLOCK 8
`define PAGE_COUNT 2048
`define ERASED_BYTE 8'hFF
`define STAT_IDLE_BIT 7
`define STAT_CMP_BIT 6
`define STAT_DENSITY 4'h7
`define CLK_PERIOD_NS 10
`define BLOCK_ERASE_TIME_NS 50000
`define ERASE_PROGRAM_TIME_NS 40000
`define TRANSFER_TIME_NS 10000
`endif

// File: pkg/serial_flash_pkg.sv
package serial_flash_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_XFER, ST_CMP} seq_state_e;
  typedef enum logic [2:0] {OP_NONE, OP_BLK, OP_PTB, OP_XFR, OP_CMPR, OP_RWR} op_kind_e;
  typedef logic [7:0] byte_t;
endpackage

// File: pkg/link_if.sv
`timescale 1ns/1ps
interface link_if;
  logic [31:0] cmd_word;
  logic done_tog;
  logic byte_tog;
  logic [7:0] byte_data;
  modport link (output cmd_word, output done_tog, output byte_tog, output byte_data);
  modport core (input cmd_word, input done_tog, input byte_tog, input byte_data);
endinterface

// File: core/flash_mem.sv
`timescale 1ns/1ps
module flash_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 264
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [DEPTH];

  if (DEPTH < 2 || DW < 1)
  begin : g_bad
    $error("flash_mem needs DEPTH >= 2 and DW >= 1");
  end

  always_ff @(posedge i_clk)
  begin
    if (i_we)
      mem[i_addr] <= i_wdata;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= '0;
    else
      o_rdata <= mem[i_addr];
  end
endmodule

// File: core/spi_cmd_link.sv
`timescale 1ns/1ps
`include "serial_flash_defines.svh"
module spi_cmd_link
  import serial_flash_pkg::*;
(
  input wire logic i_rstn,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  link_if.link lk
);
  logic fresh_reg;
  logic [`CMD_CNT_W-1:0] cnt_reg;
  logic [31:0] cmd_reg;
  logic [2:0] bitc_reg;
  logic [7:0] dat_reg;
  byte_t byte_reg;
  logic done_tog_reg;
  logic byte_tog_reg;
  logic in_cmd;
  logic rearm;

  assign in_cmd = fresh_reg || (cnt_reg != `CMD_CNT_W'(`CMD_BITS));
  // Reset arms too, else the first frame would see an unknown flag
  assign rearm = i_cs_n | ~i_rstn;

  // Deselect re-arms the frame, since sck stands still between frames
  always_ff @(posedge i_sck or posedge rearm)
  begin
    if (rearm)
      fresh_reg <= 1'b1;
    else
      fresh_reg <= 1'b0;
  end

  always_ff @(posedge i_sck or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_reg <= '0;
      done_tog_reg <= 1'b0;
    end
    else if (!i_cs_n)
    begin
      if (fresh_reg)
        cnt_reg <= `CMD_CNT_W'(1);
      else if (in_cmd)
      begin
        cnt_reg <= cnt_reg + 1'b1;
        if (cnt_reg == `CMD_CNT_W'(`CMD_BITS - 1))
          done_tog_reg <= ~done_tog_reg;
      end
    end
  end

  always_ff @(posedge i_sck or negedge i_rstn)
  begin
    if (!i_rstn)
      cmd_reg <= '0;
    else if (!i_cs_n && in_cmd)
      cmd_reg <= {cmd_reg[30:0], i_mosi};
  end

  always_ff @(posedge i_sck or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bitc_reg <= '0;
      dat_reg <= '0;
      byte_reg <= '0;
      byte_tog_reg <= 1'b0;
    end
    else if (!i_cs_n)
    begin
      if (in_cmd)
        bitc_reg <= '0;
      else
      begin
        dat_reg <= {dat_reg[6:0], i_mosi};
        bitc_reg <= bitc_reg + 1'b1;
        if (bitc_reg == 3'h7)
        begin
          byte_reg <= {dat_reg[6:0], i_mosi};
          byte_tog_reg <= ~byte_tog_reg;
        end
      end
    end
  end

  assign lk.cmd_word = cmd_reg;
  assign lk.done_tog = done_tog_reg;
  assign lk.byte_tog = byte_tog_reg;
  assign lk.byte_data = byte_reg;
endmodule

// File: core/serial_flash_array_ops.sv
`timescale 1ns/1ps
`include "serial_flash_defines.svh"
module serial_flash_array_ops
  import serial_flash_pkg::*;
#(
  parameter int PAGE_COUNT = `PAGE_COUNT,
  parameter int BLOCK_ERASE_CYCLES = `BLOCK_ERASE_TIME_NS / `CLK_PERIOD_NS,
  parameter int ERASE_PROGRAM_CYCLES = `ERASE_PROGRAM_TIME_NS / `CLK_PERIOD_NS,
  parameter int TRANSFER_CYCLES = `TRANSFER_TIME_NS / `CLK_PERIOD_NS
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic [7:0] o_status,
  output logic o_ready_out,
  output logic o_ready_oe_n
);
  localparam int PB = `PAGE_BYTES;
  localparam int BLOCK_BYTES = `PAGES_PER_BLOCK * `PAGE_BYTES;
  localparam int MAIN_AW = $clog2(PAGE_COUNT * PB);
  localparam int BUF_AW = $clog2(2 * PB);
  localparam int LEN_W = $clog2(BLOCK_BYTES + 1);

  if (PAGE_COUNT < `PAGES_PER_BLOCK || PAGE_COUNT > `PAGE_COUNT || (PAGE_COUNT & (PAGE_COUNT - 1)) != 0)
  begin : g_bad_pages
    $error("PAGE_COUNT must be a power of two from 8 to 2048");
  end
  if (BLOCK_ERASE_CYCLES < BLOCK_BYTES + 4 || ERASE_PROGRAM_CYCLES < 3 * PB + 8 || TRANSFER_CYCLES < PB + 4)
  begin : g_bad_times
    $error("Cycle budgets too short for the byte-serial array engine");
  end

  function automatic logic [MAIN_AW-1:0] main_address(input logic [10:0] page, input logic [LEN_W-1:0] off);
    int unsigned a;
    a = (int'(page) % PAGE_COUNT) * PB + int'(off);
    return MAIN_AW'(a);
  endfunction

  function automatic logic [BUF_AW-1:0] buf_address(input logic sel, input logic [LEN_W-1:0] off);
    int unsigned a;
    a = int'(sel) * PB + int'(off);
    return BUF_AW'(a);
  endfunction

  function automatic logic [8:0] next_pos(input logic [8:0] p);
    return (int'(p) >= PB - 1) ? 9'h000 : p + 9'h001;
  endfunction

  function automatic op_kind_e decode_op(input byte_t opc);
    case (opc)
      `OP_BLOCK_ERASE: return OP_BLK;
      `OP_PTB_BUF1, `OP_PTB_BUF2: return OP_PTB;
      `OP_XFER_BUF1, `OP_XFER_BUF2: return OP_XFR;
      `OP_CMP_BUF1, `OP_CMP_BUF2: return OP_CMPR;
      `OP_REWR_BUF1, `OP_REWR_BUF2: return OP_RWR;
      default: return OP_NONE;
    endcase
  endfunction

  function automatic logic buf_of(input byte_t opc);
    return (opc == `OP_PTB_BUF2) || (opc == `OP_XFER_BUF2) || (opc == `OP_CMP_BUF2) || (opc == `OP_REWR_BUF2);
  endfunction

  link_if lk();

  spi_cmd_link u_link (
    .i_rstn(i_rstn),
    .i_sck(i_sck),
    .i_cs_n(i_cs_n),
    .i_mosi(i_mosi),
    .lk(lk.link)
  );

  logic cs_s1_reg, cs_s2_reg, cs_s3_reg, cs_rise_reg;
  logic bt_s1_reg, bt_s2_reg, bt_s3_reg;
  logic dt_s1_reg, dt_s2_reg, dt_s3_reg;
  logic cs_fall, byte_ev, done_ev;
  logic got_cmd_reg, first_byte_reg;
  logic [8:0] wr_ptr_reg;
  logic [8:0] wr_pos;
  logic wr_now, start, issuing, seq_done;
  byte_t opc;
  op_kind_e kind;
  logic opc_buf;
  seq_state_e state_reg;
  logic [LEN_W-1:0] idx_reg, idx_d_reg, len_reg;
  logic vld_d_reg;
  logic [10:0] page_reg;
  logic buf_sel_reg, then_prog_reg, then_erase_reg;
  logic acc_reg, cmp_flag_reg;
  logic [31:0] busy_cnt_reg, limit_reg;
  logic main_we, buf_we;
  logic [MAIN_AW-1:0] main_addr;
  logic [BUF_AW-1:0] buf_addr;
  byte_t main_wd, buf_wd, main_rdata, buf_rdata;
  logic [7:0] status_reg;
  logic ready_oe_n_reg;
  logic ready_out_reg;

  // Pin and toggle synchronisers; edges are taken from stages two and three only
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= 3'h7;
      cs_rise_reg <= 1'b0;
      {bt_s1_reg, bt_s2_reg, bt_s3_reg} <= 3'h0;
      {dt_s1_reg, dt_s2_reg, dt_s3_reg} <= 3'h0;
    end
    else
    begin
      {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= {i_cs_n, cs_s1_reg, cs_s2_reg};
      // One extra cycle so a last byte toggle lands before the frame closes
      cs_rise_reg <= cs_s2_reg & ~cs_s3_reg;
      {bt_s1_reg, bt_s2_reg, bt_s3_reg} <= {lk.byte_tog, bt_s1_reg, bt_s2_reg};
      {dt_s1_reg, dt_s2_reg, dt_s3_reg} <= {lk.done_tog, dt_s1_reg, dt_s2_reg};
    end
  end

  assign cs_fall = ~cs_s2_reg & cs_s3_reg;
  assign byte_ev = bt_s2_reg ^ bt_s3_reg;
  assign done_ev = dt_s2_reg ^ dt_s3_reg;

  // Command word is read only once all 32 bits are in and it stops shifting, so it is quasi-static here
  assign opc = lk.cmd_word[`OPC_MSB:`OPC_LSB];
  assign kind = decode_op(opc);
  assign opc_buf = buf_of(opc);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      got_cmd_reg <= 1'b0;
    else if (done_ev)
      got_cmd_reg <= 1'b1;
    else if (cs_fall)
      got_cmd_reg <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      first_byte_reg <= 1'b1;
    else if (cs_fall)
      first_byte_reg <= 1'b1;
    else if (byte_ev)
      first_byte_reg <= 1'b0;
  end

  assign wr_pos = first_byte_reg ? lk.cmd_word[`BYTE_MSB:`BYTE_LSB] : wr_ptr_reg;
  assign wr_now = byte_ev && (kind == OP_PTB) && (state_reg == ST_IDLE);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      wr_ptr_reg <= '0;
    else if (byte_ev)
      wr_ptr_reg <= next_pos(wr_pos);
  end

  assign start = cs_rise_reg && got_cmd_reg && (kind != OP_NONE) && (state_reg == ST_IDLE);
  assign issuing = (state_reg != ST_IDLE) && (idx_reg < len_reg);
  assign seq_done = (state_reg != ST_IDLE) && !issuing && !vld_d_reg;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg <= ST_IDLE;
      idx_reg <= '0;
      idx_d_reg <= '0;
      vld_d_reg <= 1'b0;
      len_reg <= '0;
      page_reg <= '0;
      buf_sel_reg <= 1'b0;
      then_prog_reg <= 1'b0;
      then_erase_reg <= 1'b0;
      limit_reg <= '0;
    end
    else
    begin
      idx_d_reg <= idx_reg;
      vld_d_reg <= issuing;
      if (start)
      begin
        idx_reg <= '0;
        len_reg <= LEN_W'(PB);
        page_reg <= lk.cmd_word[`PAGE_MSB:`PAGE_LSB];
        buf_sel_reg <= opc_buf;
        then_prog_reg <= (kind == OP_PTB) || (kind == OP_RWR);
        then_erase_reg <= (kind == OP_RWR);
        limit_reg <= 32'(ERASE_PROGRAM_CYCLES);
        case (kind)
          OP_BLK:
          begin
            state_reg <= ST_ERASE;
            page_reg <= {lk.cmd_word[`BLOCK_MSB:`BLOCK_LSB], 3'h0};
            len_reg <= LEN_W'(BLOCK_BYTES);
            limit_reg <= 32'(BLOCK_ERASE_CYCLES);
          end
          OP_PTB: state_reg <= ST_ERASE;
          OP_XFR:
          begin
            state_reg <= ST_XFER;
            limit_reg <= 32'(TRANSFER_CYCLES);
          end
          OP_CMPR:
          begin
            state_reg <= ST_CMP;
            limit_reg <= 32'(TRANSFER_CYCLES);
          end
          OP_RWR: state_reg <= ST_XFER;
          default: state_reg <= ST_IDLE;
        endcase
      end
      else if (issuing)
        idx_reg <= idx_reg + 1'b1;
      else if (seq_done)
      begin
        idx_reg <= '0;
        len_reg <= LEN_W'(PB);
        case (state_reg)
          ST_XFER:
            state_reg <= then_erase_reg ? ST_ERASE : ST_IDLE;
          ST_ERASE:
            state_reg <= then_prog_reg ? ST_PROG : ST_IDLE;
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Memory ports; host buffer writes only reach the buffer while the engine is idle
  always_comb
  begin
    main_we = 1'b0;
    main_addr = main_address(page_reg, idx_reg);
    main_wd = `ERASED_BYTE;
    buf_we = 1'b0;
    buf_addr = buf_address(buf_sel_reg, idx_reg);
    buf_wd = main_rdata;
    case (state_reg)
      ST_ERASE: main_we = issuing;
      ST_PROG:
      begin
        main_we = vld_d_reg;
        main_addr = main_address(page_reg, idx_d_reg);
        main_wd = buf_rdata;
      end
      ST_XFER:
      begin
        buf_we = vld_d_reg;
        buf_addr = buf_address(buf_sel_reg, idx_d_reg);
      end
      ST_IDLE:
      begin
        buf_we = wr_now;
        buf_addr = buf_address(opc_buf, LEN_W'(wr_pos));
        buf_wd = lk.byte_data;
      end
      default: main_we = 1'b0;
    endcase
  end

  flash_mem #(.DW(8), .DEPTH(PAGE_COUNT * PB)) u_main (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_we(main_we),
    .i_addr(main_addr),
    .i_wdata(main_wd),
    .o_rdata(main_rdata)
  );

  flash_mem #(.DW(8), .DEPTH(2 * PB)) u_bufs (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_we(buf_we),
    .i_addr(buf_addr),
    .i_wdata(buf_wd),
    .o_rdata(buf_rdata)
  );

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      acc_reg <= 1'b0;
    else if (start)
      acc_reg <= 1'b0;
    else if (state_reg == ST_CMP && vld_d_reg && main_rdata != buf_rdata)
      acc_reg <= 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cmp_flag_reg <= 1'b0;
    else if (state_reg == ST_CMP && seq_done)
      cmp_flag_reg <= acc_reg;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      busy_cnt_reg <= '0;
    else if (state_reg == ST_IDLE)
      busy_cnt_reg <= '0;
    else
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
  end

  // Busy shows a few cycles after chip select rises, due to the crossing
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      status_reg <= {1'b1, 1'b0, `STAT_DENSITY, 2'h0};
      ready_oe_n_reg <= 1'b1;
      ready_out_reg <= 1'b0;
    end
    else
    begin
      ready_out_reg <= 1'b0; // Open drain only ever pulls low
      status_reg <= {state_reg == ST_IDLE, cmp_flag_reg, `STAT_DENSITY, 2'h0};
      ready_oe_n_reg <= (state_reg == ST_IDLE);
    end
  end

  assign o_status = status_reg;
  assign o_ready_oe_n = ready_oe_n_reg;
  assign o_ready_out = ready_out_reg;

  property p_idle_flag;
    @(posedge i_clk) disable iff (!i_rstn) ##1 o_status[`STAT_IDLE_BIT] == $past(state_reg == ST_IDLE);
  endproperty
  a_idle_flag: assert property (p_idle_flag) else $error("idle flag does not track engine");

  property p_pin;
    @(posedge i_clk) disable iff (!i_rstn) o_ready_oe_n == o_status[`STAT_IDLE_BIT];
  endproperty
  a_pin: assert property (p_pin) else $error("ready pin disagrees with status");

  property p_start;
    @(posedge i_clk) disable iff (!i_rstn) start |=> (state_reg != ST_IDLE) ##1 !o_status[`STAT_IDLE_BIT];
  endproperty
  a_start: assert property (p_start) else $error("operation did not start");

  property p_discard;
    @(posedge i_clk) disable iff (!i_rstn) (cs_rise_reg && !got_cmd_reg && state_reg == ST_IDLE) |=> state_reg == ST_IDLE;
  endproperty
  a_discard: assert property (p_discard) else $error("short command was started");

  property p_bound;
    @(posedge i_clk) disable iff (!i_rstn) (state_reg != ST_IDLE) |-> busy_cnt_reg < limit_reg;
  endproperty
  a_bound: assert property (p_bound) else $error("busy time exceeded");

  property p_erase_ff;
    @(posedge i_clk) disable iff (!i_rstn) (state_reg == ST_ERASE && issuing) |-> main_we && main_wd == `ERASED_BYTE;
  endproperty
  a_erase_ff: assert property (p_erase_ff) else $error("erase wrote non-erased data");

  property p_cmp_flag;
    @(posedge i_clk) disable iff (!i_rstn) (state_reg == ST_CMP && seq_done) |-> ##2 o_status[`STAT_CMP_BIT] == $past(acc_reg, 2);
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not updated");

  property p_wrap;
    @(posedge i_clk) disable iff (!i_rstn) (byte_ev && int'(wr_pos) == PB - 1) |=> wr_ptr_reg == 9'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("buffer pointer did not wrap");

  property p_block;
    @(posedge i_clk) disable iff (!i_rstn) (start && kind == OP_BLK) |=> page_reg[2:0] == 3'h0 && int'(len_reg) == BLOCK_BYTES;
  endproperty
  a_block: assert property (p_block) else $error("block erase range wrong");

  property p_chain;
    @(posedge i_clk) disable iff (!i_rstn) (state_reg == ST_XFER && seq_done && then_erase_reg) |=> state_reg == ST_ERASE;
  endproperty
  a_chain: assert property (p_chain) else $error("rewrite did not erase after copy");
endmodule

// File: dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi
);
  localparam time HALF = 80ns;
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Mode 0: data set while sck low, device samples on rise; sck still between frames
  task automatic send(input logic [7:0] op, input logic [23:0] adr, input int nbytes, input logic [7:0] dat,
                      input int nbits);
    logic [31:0] word;
    int i;
    word = {op, adr};
    #3;
    o_cs_n = 1'b0; // Held low across every clocked bit
    for (i = 0; i < nbits + 8 * nbytes; i++)
    begin
      o_mosi = (i < 32) ? word[31 - i] : dat[7 - (i - 32) % 8]; // MSB first
      #HALF o_sck = 1'b1;
      #HALF o_sck = 1'b0;
    end
    #HALF o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line must not show a stale bit
  endtask
endmodule

// File: dv/tb_serial_flash_array_ops.sv
`timescale 1ns/1ps
`include "serial_flash_defines.svh"
`define CHK(name, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
    end \
  end
module tb_serial_flash_array_ops;
  import serial_flash_pkg::*;
  // Budgets cut down to keep the run short, still above the engine minimums
  localparam int BE_CYC = 2200;
  localparam int EP_CYC = 900;
  localparam int XF_CYC = 300;
  logic i_clk;
  logic i_rstn;
  wire sck;
  wire cs_n;
  wire mosi;
  logic [7:0] o_status;
  logic o_ready_out;
  logic o_ready_oe_n;
  wire ready_pin = o_ready_oe_n ? 1'b1 : o_ready_out; // External pull-up
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  serial_flash_array_ops #(
    .PAGE_COUNT(64),
    .BLOCK_ERASE_CYCLES(BE_CYC),
    .ERASE_PROGRAM_CYCLES(EP_CYC),
    .TRANSFER_CYCLES(XF_CYC)
  ) i_serial_flash_array_ops (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_sck(sck),
    .i_cs_n(cs_n),
    .i_mosi(mosi),
    .o_status(o_status),
    .o_ready_out(o_ready_out),
    .o_ready_oe_n(o_ready_oe_n)
  );

  spi_host_model i_spi_host_model (
    .o_sck(sck),
    .o_cs_n(cs_n),
    .o_mosi(mosi)
  );

  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  task automatic final_report;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic cmd(input logic [7:0] op, input logic [10:0] page, input logic [8:0] bofs, input int nbytes,
                     input int nbits);
    @(negedge i_clk);
    i_spi_host_model.send(op, {4'h0, page, bofs}, nbytes, 8'h00, nbits);
  endtask

  // Host only issues the next array command once idle, within the budget passed for that operation
  task automatic wait_op(input string what, input int bound);
    int n;
    logic pin_bad;
    n = 0;
    pin_bad = 1'b0;
    while (o_status[7] !== 1'b0 && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    `CHK({what, " busy"}, 1'b0, o_status[7])
    n = 0;
    while (o_status[7] === 1'b0 && n <= bound)
    begin
      if (ready_pin !== 1'b0)
        pin_bad = 1'b1;
      @(negedge i_clk);
      n++;
    end
    `CHK({what, " pin low while busy"}, 1'b0, pin_bad)
    `CHK({what, " within budget"}, 1'b1, n <= bound)
    @(negedge i_clk);
    `CHK({what, " idle"}, 1'b1, o_status[7])
    `CHK({what, " pin released"}, 1'b1, ready_pin)
  endtask

  task automatic cmp(input logic [7:0] op, input logic [10:0] page, input logic exp);
    cmd(op, page, 9'h000, 0, 32);
    wait_op("compare", XF_CYC);
    `CHK("mismatch flag", exp, o_status[6])
    `CHK("fixed status bits", 6'h1C, o_status[5:0])
  endtask

  task automatic t_reset;
    `CHK("reset status", 8'h9C, o_status)
    `CHK("reset pin", 1'b1, ready_pin)
    `CHK("pin data", 1'b0, o_ready_out)
  endtask

  // Block 0 named through page 7: low page bits must be ignored
  task automatic t_erase;
    cmd(`OP_BLOCK_ERASE, 11'h007, 9'h000, 0, 32);
    wait_op("block erase", BE_CYC);
    cmd(`OP_XFER_BUF1, 11'h001, 9'h000, 0, 32);
    wait_op("transfer", XF_CYC);
    cmp(`OP_CMP_BUF1, 11'h007, 1'b0);
  endtask

  // Same zero bytes reach both buffers, one by wrapping and one by direct writes
  task automatic t_program;
    cmd(`OP_XFER_BUF2, 11'h000, 9'h000, 0, 32);
    wait_op("transfer", XF_CYC);
    cmd(`OP_PTB_BUF2, 11'h009, 9'h106, 5, 32);
    wait_op("program", EP_CYC);
    cmd(`OP_PTB_BUF1, 11'h00A, 9'h000, 3, 32);
    wait_op("program", EP_CYC);
    cmd(`OP_PTB_BUF1, 11'h00B, 9'h106, 2, 32);
    wait_op("program", EP_CYC);
    cmp(`OP_CMP_BUF1, 11'h009, 1'b0);
    cmp(`OP_CMP_BUF1, 11'h000, 1'b1);
  endtask

  task automatic t_rewrite;
    cmd(`OP_REWR_BUF1, 11'h009, 9'h000, 0, 32);
    wait_op("rewrite", EP_CYC);
    cmp(`OP_CMP_BUF2, 11'h009, 1'b0);
    cmd(`OP_REWR_BUF2, 11'h000, 9'h000, 0, 32);
    wait_op("rewrite", EP_CYC);
    cmp(`OP_CMP_BUF2, 11'h000, 1'b0);
    cmp(`OP_CMP_BUF2, 11'h009, 1'b1);
  endtask

  // Erase of page 9's block cut after 16 bits must leave page 9 intact
  task automatic t_cut;
    cmd(`OP_BLOCK_ERASE, 11'h009, 9'h000, 0, 16);
    repeat (30) @(negedge i_clk);
    `CHK("cut frame idle", 1'b1, o_status[7])
    `CHK("cut frame pin", 1'b1, ready_pin)
    cmp(`OP_CMP_BUF1, 11'h009, 1'b0);
  endtask

  initial
  begin
    i_rstn = 1'b0;
    repeat (6) @(negedge i_clk);
    t_reset();
    i_rstn = 1'b1;
    repeat (6) @(negedge i_clk);
    t_erase();
    t_program();
    t_rewrite();
    t_cut();
    final_report();
  end
endmodule
